// *** core/irq_pkg.sv ***
package irq_pkg;
  localparam int NUM_SRC = 12;
  localparam int VEC_W = 16;
  localparam int REG_W = 8;
  localparam int MC_CLOCKS = 6;
  // register offsets on the plain register port
  localparam logic [3:0] OFF_EN_LOW = 4'h0;
  localparam logic [3:0] OFF_EN_HIGH = 4'h1;
  localparam logic [3:0] OFF_PRI_LOW_A = 4'h2;
  localparam logic [3:0] OFF_PRI_HIGH_A = 4'h3;
  localparam logic [3:0] OFF_PRI_LOW_B = 4'h4;
  localparam logic [3:0] OFF_PRI_HIGH_B = 4'h5;
  localparam logic [3:0] OFF_STATUS = 4'h6;
  localparam logic [3:0] OFF_MASK = 4'h7;
  localparam logic [3:0] OFF_ACTIVE = 4'h8;
  localparam logic [3:0] OFF_STATUS_HI = 4'h9;
  localparam logic [3:0] OFF_MASK_HI = 4'ha;
  localparam int GIE_BIT = 7;
  localparam logic [7:0] RST_REG = 8'h00;
  // source indices
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_BROWN = 5;
  localparam int SRC_SBUS = 6;
  localparam int SRC_KEYP = 7;
  localparam int SRC_CMP2 = 8;
  localparam int SRC_WDOG = 9;
  localparam int SRC_CMP1 = 10;
  localparam int SRC_BTMO = 11;
  // enable bit position of each source in the 16-bit {high,low} enable word
  localparam int EN_POS [NUM_SRC] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 6, 13, 15};
  localparam logic [VEC_W-1:0] VECTOR [NUM_SRC] = '{16'h0003, 16'h000b, 16'h0013,
    16'h001b, 16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h0063,
    16'h0073};
  // polling rank, 1 is highest
  localparam int RANK [NUM_SRC] = '{1, 4, 6, 9, 11, 2, 5, 7, 10, 3, 8, 12};
  // wake-capable sources: ext0, ext1, brownout, keypad, cmp2, watchdog, cmp1
  localparam logic [NUM_SRC-1:0] WAKE_MASK = 12'h7a5;
endpackage

// *** core/irq_arb_if.sv ***
interface irq_arb_if;
  logic [11:0] req;
  logic [23:0] lvl;
  logic found;
  logic [3:0] src;
  logic [1:0] level;
  modport top (output req, output lvl, input found, input src, input level);
  modport arb (input req, input lvl, output found, output src, output level);
endinterface

// *** core/irq_arbiter.sv ***
// picks the highest level, then best polling rank, among requesting sources
module irq_arbiter (
  irq_arb_if.arb a
);
  always_comb begin
    int best_rank;
    best_rank = 13;
    a.found = 1'b0;
    a.src = 4'h0;
    a.level = 2'h0;
    for (int i = 0; i < irq_pkg::NUM_SRC; i++) begin
      if (a.req[i] && (!a.found || a.lvl[2*i +: 2] > a.level ||
          (a.lvl[2*i +: 2] == a.level && irq_pkg::RANK[i] < best_rank))) begin
        a.found = 1'b1;
        a.src = 4'(i);
        a.level = a.lvl[2*i +: 2];
        best_rank = irq_pkg::RANK[i];
      end
    end
  end
endmodule // irq_arbiter

// *** core/four_level_interrupt_controller.sv ***
// Functional notes
// - four priority levels per source
// - twelve request inputs with own flags
// - per-source enable bit gates each request
// - global enable clear blocks every source
// - level from high and low priority bits
// - preempt only by strictly higher level
// - higher level wins among simultaneous requests
// - equal level resolved by fixed polling rank
// - vectors for first six sources
// - vectors for remaining six sources
// - only listed sources wake from power-down
// - serial-bus attention requests when enabled
module four_level_interrupt_controller #(
  // clocks per machine cycle; the tick counter serves 1 to 16
  parameter int CLOCKS_PER_MC = irq_pkg::MC_CLOCKS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // request flags from peripherals (same clock domain)
  input wire logic [11:0] request_flags_i,
  // cpu core handshake
  output logic irq_req_o,
  output logic [15:0] vector_o,
  input wire logic vector_ack_i,
  input wire logic reti_i,
  // power-down wake and housekeeping interrupt
  output logic wakeup_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] enable_register_low;
  logic [7:0] enable_register_high;
  logic [7:0] priority_low_bits_a;
  logic [7:0] priority_high_bits_a;
  logic [7:0] priority_low_bits_b;
  logic [7:0] priority_high_bits_b;
  logic [11:0] event_status;
  logic [11:0] event_mask;
  logic [3:0] active_levels;
  logic [3:0] mc_count;
  logic mc_tick;
  logic [11:0] gated;
  logic [15:0] en_word;
  logic [23:0] levels;
  logic [7:0] next_rdata;
  logic [11:0] flags_q;
  logic [11:0] rise;
  logic [11:0] clr_stat;
  logic [1:0] cur_level;
  logic any_active;
  logic [3:0] next_active;
  logic [1:0] pend_level;
  logic pending;

  irq_arb_if arb_bus ();

  // the tick counter is four bits wide, so longer machine cycles are refused
  if (CLOCKS_PER_MC < 1 || CLOCKS_PER_MC > 16) begin : g_mc_range
    $error("machine cycle length out of range");
  end

  // level of one source from its two priority bits
  function automatic logic [1:0] src_level(input int i, input logic [7:0] ha,
      input logic [7:0] la, input logic [7:0] hb, input logic [7:0] lb);
    int p;
    p = irq_pkg::EN_POS[i];
    if (p < 8) begin
      src_level = {ha[p], la[p]};
    end else begin
      src_level = {hb[p-8], lb[p-8]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // machine cycle tick: arbitration only samples once per machine cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mc_count <= 4'h0;
    end else if (mc_count == 4'(CLOCKS_PER_MC - 1)) begin
      mc_count <= 4'h0;
    end else begin
      mc_count <= mc_count + 4'h1;
    end
  end
  assign mc_tick = (mc_count == 4'(CLOCKS_PER_MC - 1));

  ////////////////////////////////////////////////////////////////////////
  // software writes to configuration
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_register_low <= irq_pkg::RST_REG;
      enable_register_high <= irq_pkg::RST_REG;
      priority_low_bits_a <= irq_pkg::RST_REG;
      priority_high_bits_a <= irq_pkg::RST_REG;
      priority_low_bits_b <= irq_pkg::RST_REG;
      priority_high_bits_b <= irq_pkg::RST_REG;
      event_mask <= 12'h000;
    end else if (wr_i) begin
      case (addr_i)
        irq_pkg::OFF_EN_LOW: enable_register_low <= wdata_i;
        irq_pkg::OFF_EN_HIGH: enable_register_high <= wdata_i;
        irq_pkg::OFF_PRI_LOW_A: priority_low_bits_a <= wdata_i;
        irq_pkg::OFF_PRI_HIGH_A: priority_high_bits_a <= wdata_i;
        irq_pkg::OFF_PRI_LOW_B: priority_low_bits_b <= wdata_i;
        irq_pkg::OFF_PRI_HIGH_B: priority_high_bits_b <= wdata_i;
        irq_pkg::OFF_MASK: event_mask[7:0] <= wdata_i;
        irq_pkg::OFF_MASK_HI: event_mask[11:8] <= wdata_i[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gating of request flags by enables
  always_comb begin
    en_word = {enable_register_high, enable_register_low};
    for (int i = 0; i < irq_pkg::NUM_SRC; i++) begin
      // a cleared global enable blocks all, a cleared own bit blocks one
      gated[i] = request_flags_i[i] && en_word[irq_pkg::EN_POS[i]]
                 && enable_register_low[irq_pkg::GIE_BIT];
      levels[2*i +: 2] = src_level(i, priority_high_bits_a, priority_low_bits_a,
                                   priority_high_bits_b, priority_low_bits_b);
    end
  end

  assign arb_bus.req = gated;
  assign arb_bus.lvl = levels;
  irq_arbiter u_arb (
    .a(arb_bus.arb)
  );

  ////////////////////////////////////////////////////////////////////////
  // highest level currently in service
  always_comb begin
    cur_level = 2'h0;
    any_active = |active_levels;
    for (int l = 0; l < 4; l++) begin
      if (active_levels[l]) begin
        cur_level = 2'(l);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latch the winner each machine cycle; held until acknowledged or the next tick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending <= 1'b0;
      pend_level <= 2'h0;
    end else if (vector_ack_i && pending) begin
      pending <= 1'b0;
    end else if (mc_tick) begin
      // a level-3 handler blocks all since nothing is strictly above it
      pending <= arb_bus.found && (!any_active || arb_bus.level > cur_level);
      // a request withdrawn before the tick drops the pending flag
      pend_level <= arb_bus.level;
    end
  end

  assign irq_req_o = pending;

  // vector latched with the winner, so the core fetches the level it acknowledges
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_o <= 16'h0000;
    end else if (mc_tick && !(vector_ack_i && pending)) begin
      vector_o <= irq_pkg::VECTOR[arb_bus.src];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active level stack: ack marks a level, return releases the highest;
  // both in one cycle are applied, the release first
  always_comb begin
    next_active = active_levels;
    if (reti_i && any_active) begin
      next_active[cur_level] = 1'b0;
    end
    if (vector_ack_i && pending) begin
      next_active[pend_level] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_levels <= 4'h0;
    end else begin
      active_levels <= next_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake from power-down: only wake-capable gated sources
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wakeup_o <= 1'b0;
    end else begin
      wakeup_o <= |(gated & irq_pkg::WAKE_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event status: rising request flags; set beats clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_q <= 12'h000;
    end else begin
      flags_q <= request_flags_i;
    end
  end
  assign rise = request_flags_i & ~flags_q;

  always_comb begin
    clr_stat = 12'h000;
    if (wr_i && addr_i == irq_pkg::OFF_STATUS) begin
      clr_stat[7:0] = wdata_i;
    end
    if (wr_i && addr_i == irq_pkg::OFF_STATUS_HI) begin
      clr_stat[11:8] = wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_status <= 12'h000;
    end else begin
      event_status <= (event_status & ~clr_stat) | rise;
    end
  end

  // a set mask bit hides its status bit from the interrupt line
  assign irq_o = |(event_status & ~event_mask);

  ////////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      irq_pkg::OFF_EN_LOW: next_rdata = enable_register_low;
      irq_pkg::OFF_EN_HIGH: next_rdata = enable_register_high;
      irq_pkg::OFF_PRI_LOW_A: next_rdata = priority_low_bits_a;
      irq_pkg::OFF_PRI_HIGH_A: next_rdata = priority_high_bits_a;
      irq_pkg::OFF_PRI_LOW_B: next_rdata = priority_low_bits_b;
      irq_pkg::OFF_PRI_HIGH_B: next_rdata = priority_high_bits_b;
      irq_pkg::OFF_STATUS: next_rdata = event_status[7:0];
      irq_pkg::OFF_MASK: next_rdata = event_mask[7:0];
      irq_pkg::OFF_ACTIVE: next_rdata = {4'h0, active_levels};
      irq_pkg::OFF_STATUS_HI: next_rdata = {4'h0, event_status[11:8]};
      irq_pkg::OFF_MASK_HI: next_rdata = {4'h0, event_mask[11:8]};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // four_level_interrupt_controller

// *** verification/irq_ctrl_monitor.sv ***
module irq_ctrl_monitor (
  // clock, reset and register port
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // sources and core side
  input wire logic [11:0] request_flags_i,
  input wire logic irq_req_o,
  input wire logic [15:0] vector_o,
  input wire logic vector_ack_i,
  input wire logic reti_i,
  input wire logic wakeup_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned gap;
  logic seen;
  // edges since the last request rise; rises must fall on the machine-cycle grid
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap <= 0;
      seen <= 1'b0;
    end else if (irq_req_o && !$past(irq_req_o)) begin
      gap <= 1;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wait; irq_req_o && !vector_ack_i; endsequence
  sequence s_take; irq_req_o && vector_ack_i; endsequence
  req_hold_a: assert property (s_wait |=> irq_req_o) else $error("request dropped");
  ack_clear_a: assert property (s_take |=> !irq_req_o) else $error("request kept");
  vec_legal_a: assert property (s_take |-> vector_o inside {irq_pkg::VECTOR})
    else $error("vector not in table");
  req_cause_a: assert property ($rose(irq_req_o) |->
    ($past(request_flags_i) | $past(request_flags_i, 2)) != 12'h000) else $error("no cause");
  tick_grid_a: assert property ($rose(irq_req_o) && seen |-> gap % irq_pkg::MC_CLOCKS == 0)
    else $error("request off grid");
  wake_cause_a: assert property (wakeup_o |->
    (($past(request_flags_i) | $past(request_flags_i, 2)) & irq_pkg::WAKE_MASK) != 12'h000)
    else $error("wake without source");
  rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("irq fell without write");
endmodule // irq_ctrl_monitor

// *** verification/core_model.sv ***
module core_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic irq_req_i,
  input wire logic [15:0] vector_i,
  output logic vector_ack_o,
  output logic reti_o,
  // bench control: stall before taking, return command, record
  input wire logic [3:0] delay_i,
  input wire logic reti_cmd_i,
  output logic [15:0] taken_vec_o,
  output logic [7:0] taken_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // takes a vector after a chosen stall, as at an instruction boundary
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_ack_o <= 1'b0;
      reti_o <= 1'b0;
      wait_cnt <= 4'h0;
      taken_vec_o <= 16'h0000;
      taken_cnt_o <= 8'h00;
    end else begin
      vector_ack_o <= 1'b0;
      reti_o <= reti_cmd_i;
      if (irq_req_i && !vector_ack_o) begin
        if (wait_cnt >= delay_i) begin
          vector_ack_o <= 1'b1;
          taken_vec_o <= vector_i;
          taken_cnt_o <= taken_cnt_o + 8'h01;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // core_model

// *** verification/tb_four_level_interrupt_controller.sv ***
module tb_four_level_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [11:0] request_flags_i = 12'h000;
  logic [3:0] delay = 4'h0;
  logic reti_cmd = 1'b0;
  logic irq_req_o, vector_ack_i, reti_i, wakeup_o, irq_o;
  logic [15:0] vector_o, taken_vec;
  logic [7:0] rdata_o, taken_cnt, rv;
  logic [23:0] lv;
  logic [11:0] f;
  int fails = 0;
  int samples_checked = 0;
  int w;
  always #2.5 clk_i = ~clk_i;
  four_level_interrupt_controller u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .request_flags_i(request_flags_i), .irq_req_o(irq_req_o), .vector_o(vector_o),
    .vector_ack_i(vector_ack_i), .reti_i(reti_i), .wakeup_o(wakeup_o), .irq_o(irq_o));
  core_model u_core (.clk_i(clk_i), .resetn_i(resetn_i), .irq_req_i(irq_req_o),
    .vector_i(vector_o), .vector_ack_o(vector_ack_i), .reti_o(reti_i), .delay_i(delay),
    .reti_cmd_i(reti_cmd), .taken_vec_o(taken_vec), .taken_cnt_o(taken_cnt));
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read strobe for one cycle, data taken in the following cycle only
  task automatic rdchk(string what, logic [3:0] a, logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check(what, {8'h00, exp}, {8'h00, rdata_o});
  endtask
  // level pairs and enables placed at each source's bit position
  task automatic setup(logic [23:0] l, logic [11:0] en, logic gie);
    logic [15:0] e, hi, lo;
    e = 16'h0000;
    hi = 16'h0000;
    lo = 16'h0000;
    for (int s = 0; s < 12; s++) begin
      e[irq_pkg::EN_POS[s]] = en[s];
      hi[irq_pkg::EN_POS[s]] = l[2*s+1];
      lo[irq_pkg::EN_POS[s]] = l[2*s];
    end
    e[irq_pkg::GIE_BIT] = gie;
    wr(irq_pkg::OFF_EN_LOW, e[7:0]);
    wr(irq_pkg::OFF_EN_HIGH, e[15:8]);
    wr(irq_pkg::OFF_PRI_LOW_A, lo[7:0]);
    wr(irq_pkg::OFF_PRI_HIGH_A, hi[7:0]);
    wr(irq_pkg::OFF_PRI_LOW_B, lo[15:8]);
    wr(irq_pkg::OFF_PRI_HIGH_B, hi[15:8]);
  endtask
  // bounded wait for the core to take a vector; a miss shows as unknown
  task automatic take(string what, logic [15:0] exp);
    logic [7:0] c0;
    c0 = taken_cnt;
    w = 0;
    while (taken_cnt == c0 && w < 100) begin
      @(posedge clk_i);
      w++;
    end
    check(what, exp, (w < 100) ? taken_vec : 16'hxxxx);
  endtask
  task automatic quiet(string what);
    logic [7:0] c0;
    c0 = taken_cnt;
    repeat (3 * irq_pkg::MC_CLOCKS) @(posedge clk_i);
    check(what, {8'h00, c0}, {8'h00, taken_cnt});
  endtask
  task automatic ret();
    @(posedge clk_i);
    reti_cmd <= 1'b1;
    @(posedge clk_i);
    reti_cmd <= 1'b0;
  endtask
  // highest level first, polling rank only among equals
  function automatic int winner(logic [11:0] fl, logic [23:0] l);
    int b;
    b = -1;
    for (int s = 0; s < 12; s++) begin
      if (fl[s] && (b < 0 || l[2*s+:2] > l[2*b+:2] ||
          (l[2*s+:2] == l[2*b+:2] && irq_pkg::RANK[s] < irq_pkg::RANK[b]))) begin
        b = s;
      end
    end
    return b;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h467a386d));
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      if (a < 11 || a == 15) rdchk("reset value", 4'(a), irq_pkg::RST_REG);
    end
    for (int s = 0; s < 12; s++) begin
      setup(24'h000000, 12'hfff, 1'b1);
      request_flags_i <= 12'h001 << s;
      take("vector", irq_pkg::VECTOR[s]);
      check("wakeup", {15'h0000, irq_pkg::WAKE_MASK[s]}, {15'h0000, wakeup_o});
      request_flags_i <= 12'h000;
      ret();
      setup(24'h000000, ~(12'h001 << s), 1'b1);
      request_flags_i <= 12'h001 << s;
      quiet("disabled source");
      setup(24'h000000, 12'hfff, 1'b0);
      quiet("global enable off");
      request_flags_i <= 12'h000;
    end
    // random levels and requests; first two are all-equal corner cases
    for (int i = 0; i < 24; i++) begin
      lv = (i < 2) ? 24'h000000 : 24'($urandom());
      f = (i < 2) ? 12'hfff << i : 12'($urandom_range(1, 4095));
      delay <= 4'($urandom_range(0, 9));
      setup(lv, 12'hfff, 1'b1);
      request_flags_i <= f;
      take("winner", irq_pkg::VECTOR[winner(f, lv)]);
      request_flags_i <= 12'h000;
      ret();
    end
    // nesting: only a strictly higher level may break in
    setup(24'hc00217, 12'hfff, 1'b1);
    request_flags_i <= 12'h004;
    take("level one", irq_pkg::VECTOR[irq_pkg::SRC_EXT1]);
    request_flags_i <= 12'h006;
    quiet("equal level");
    request_flags_i <= 12'h016;
    take("level two", irq_pkg::VECTOR[irq_pkg::SRC_SER]);
    request_flags_i <= 12'h816;
    take("level three", irq_pkg::VECTOR[irq_pkg::SRC_BTMO]);
    request_flags_i <= 12'h817;
    quiet("top level");
    rdchk("active levels", irq_pkg::OFF_ACTIVE, 8'h0e);
    request_flags_i <= 12'h000;
    ret();
    rdchk("after return", irq_pkg::OFF_ACTIVE, 8'h06);
    // sticky status, mask, write one to clear
    wr(irq_pkg::OFF_STATUS, 8'hff);
    wr(irq_pkg::OFF_STATUS_HI, 8'h0f);
    request_flags_i <= 12'h880;
    repeat (4) @(posedge clk_i);
    rdchk("status", irq_pkg::OFF_STATUS, 8'h80);
    rdchk("status high", irq_pkg::OFF_STATUS_HI, 8'h08);
    wr(irq_pkg::OFF_STATUS_HI, 8'h08);
    wr(irq_pkg::OFF_MASK, 8'h80);
    repeat (2) @(negedge clk_i);
    check("masked irq", 16'h0000, {15'h0000, irq_o});
    wr(irq_pkg::OFF_MASK, 8'h00);
    repeat (2) @(negedge clk_i);
    check("unmasked irq", 16'h0001, {15'h0000, irq_o});
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    summarize();
  end
endmodule // tb_four_level_interrupt_controller

bind four_level_interrupt_controller irq_ctrl_monitor u_mon (.clk_i(clk_i),
  .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .request_flags_i(request_flags_i), .irq_req_o(irq_req_o),
  .vector_o(vector_o), .vector_ack_i(vector_ack_i), .reti_i(reti_i), .wakeup_o(wakeup_o),
  .irq_o(irq_o));
